// file: rtl/wir_pkg.sv
// shared constants and state layout for the axi3 write id regenerator
package wir_pkg;
  // ----------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------
  localparam int ID_W = 12;
  localparam int ADDR_W = 48;
  localparam int DATA_W = 64;
  localparam int STRB_W = DATA_W / 8;
  localparam int UP_LEN_W = 8;
  localparam int DN_LEN_W = 4;
  localparam int WBEAT_W = DATA_W + STRB_W + 1;
  // ----------------------------------------------------------------
  // buffer depths
  // ----------------------------------------------------------------
  localparam int ID_DEPTH = 128;
  localparam int W_DEPTH = 8;
  localparam int ID_CNT_W = $clog2(ID_DEPTH + 1);
  // one slot kept spare because the address ready is decided a cycle early
  localparam logic [ID_CNT_W-1:0] ID_ROOM_MARK = ID_CNT_W'(ID_DEPTH - 1);
  // ----------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------
  localparam logic LOCKED_BIT_OFF = 1'b0;
  localparam logic [ID_W-1:0] WID_AXI4_VALUE = 12'h000;
  localparam logic [1:0] RST_SYNC_VALUE = 2'h0;

  typedef struct packed {
    logic awready;
    logic aw_v;
    logic [ADDR_W-1:0] awaddr;
    logic [ID_W-1:0] awid;
    logic [DN_LEN_W-1:0] awlen;
    logic [2:0] awsize;
    logic [1:0] awburst;
    logic [1:0] awlock;
    logic w_v;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic wlast;
    logic [ID_W-1:0] wid;
  } wir_state_t;
endpackage

// file: rtl/wir_axi3_wid_regen.sv
// axi3 write id regenerator: id fifo, write data fifo and downstream stages
// Operation
// - with axi3 mode tie-off high, wid is regenerated from the id fifo; tied low, wid is held at 0 for axi4
// - downstream write bursts leave in the order their addresses were issued
// - the one upstream lock bit drives the low bit of the two-bit axi3 lock; locked axi3 transfers are never produced
// - id fifo depth is 128, but one slot is kept spare, so in axi3 mode at most 127 writes are outstanding
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// generic fifo
// ------------------------------------------------------------------
module wir_fifo
  import wir_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic full;
    logic empty;
  } wir_fifo_state_t;

  wir_fifo_state_t s;
  wir_fifo_state_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid_in && !s.full;
  assign pop = out_ready_in && !s.empty;

  always_comb begin
    next_s = s;
    next_s.wp = s.wp + PW'(push);
    next_s.rp = s.rp + PW'(pop);
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    next_s.full = (next_s.cnt == CW'(DEPTH));
    next_s.empty = (next_s.cnt == '0);
  end

  // pointers and flags clear together, so the fifo restarts empty
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[s.wp] <= in_data_in;
    end
  end

  assign in_ready_out = !s.full;
  assign out_valid_out = !s.empty;
  assign out_data_out = mem[s.rp];
  assign count_out = s.cnt;
endmodule

// ------------------------------------------------------------------
// top: upstream axi4 write channels to downstream axi3 write channels
// ------------------------------------------------------------------
module wir_axi3_wid_regen
  import wir_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic axi3_mode_in,
  input wire logic up_awvalid_in,
  output logic up_awready_out,
  input wire logic [ADDR_W-1:0] up_awaddr_in,
  input wire logic [ID_W-1:0] up_awid_in,
  input wire logic [UP_LEN_W-1:0] up_awlen_in,
  input wire logic [2:0] up_awsize_in,
  input wire logic [1:0] up_awburst_in,
  input wire logic up_awlock_in,
  input wire logic up_wvalid_in,
  output logic up_wready_out,
  input wire logic [DATA_W-1:0] up_wdata_in,
  input wire logic [STRB_W-1:0] up_wstrb_in,
  input wire logic up_wlast_in,
  output logic dn_awvalid_out,
  input wire logic dn_awready_in,
  output logic [ADDR_W-1:0] dn_awaddr_out,
  output logic [ID_W-1:0] dn_awid_out,
  output logic [DN_LEN_W-1:0] dn_awlen_out,
  output logic [2:0] dn_awsize_out,
  output logic [1:0] dn_awburst_out,
  output logic [1:0] dn_awlock_out,
  output logic dn_wvalid_out,
  input wire logic dn_wready_in,
  output logic [ID_W-1:0] dn_wid_out,
  output logic [DATA_W-1:0] dn_wdata_out,
  output logic [STRB_W-1:0] dn_wstrb_out,
  output logic dn_wlast_out
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync <= RST_SYNC_VALUE;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  wir_state_t s;
  wir_state_t next_s;
  logic aw_acc;
  logic id_push;
  logic id_pop;
  logic id_valid;
  logic [ID_W-1:0] id_head;
  logic [ID_CNT_W-1:0] id_cnt;
  localparam int WF_CNT_W = $clog2(W_DEPTH + 1);
  logic wf_valid;
  logic wf_ready;
  logic wf_push;
  logic [WF_CNT_W-1:0] wf_cnt;
  logic [WF_CNT_W-1:0] next_wf_cnt;
  logic [WBEAT_W-1:0] wf_data;
  logic w_load;

  // id order matches address order, so the head always names the next burst
  wir_fifo #(.WIDTH(ID_W), .DEPTH(ID_DEPTH)) u_id_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .in_valid_in(id_push),
    .in_ready_out(),
    .in_data_in(up_awid_in),
    .out_valid_out(id_valid),
    .out_ready_in(id_pop),
    .out_data_out(id_head),
    .count_out(id_cnt)
  );

  // beats may arrive before their address; in axi3 mode they wait here, stalling upstream
  wir_fifo #(.WIDTH(WBEAT_W), .DEPTH(W_DEPTH)) u_w_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .in_valid_in(wf_push),
    .in_ready_out(),
    .in_data_in({up_wdata_in, up_wstrb_in, up_wlast_in}),
    .out_valid_out(wf_valid),
    .out_ready_in(wf_ready),
    .out_data_out(wf_data),
    .count_out(wf_cnt)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign aw_acc = up_awvalid_in && s.awready;
  assign id_push = aw_acc && axi3_mode_in;
  assign w_load = (!s.w_v || dn_wready_in) && wf_valid && (!axi3_mode_in || id_valid);
  assign wf_ready = w_load;
  assign id_pop = w_load && wf_data[0] && axi3_mode_in;
  // ready is registered, so it is judged on the next fill level; no accepted beat is lost
  assign wf_push = up_wvalid_in && up_wready_out;
  assign next_wf_cnt = wf_cnt + WF_CNT_W'(wf_push) - WF_CNT_W'(w_load);

  always_comb begin
    next_s = s;
    if (s.aw_v && dn_awready_in) begin
      next_s.aw_v = 1'b0;
    end
    if (aw_acc) begin
      next_s.aw_v = 1'b1;
      next_s.awaddr = up_awaddr_in;
      next_s.awid = up_awid_in;
      next_s.awlen = up_awlen_in[DN_LEN_W-1:0];
      next_s.awsize = up_awsize_in;
      next_s.awburst = up_awburst_in;
      next_s.awlock = {LOCKED_BIT_OFF, up_awlock_in};
    end
    // registered ready costs a bubble per address but keeps the port glitch free
    next_s.awready = !next_s.aw_v && (!axi3_mode_in || id_cnt < ID_ROOM_MARK);
    if (s.w_v && dn_wready_in) begin
      next_s.w_v = 1'b0;
    end
    if (w_load) begin
      next_s.w_v = 1'b1;
      {next_s.wdata, next_s.wstrb, next_s.wlast} = wf_data;
      next_s.wid = axi3_mode_in ? id_head : WID_AXI4_VALUE;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      up_wready_out <= 1'b0;
    end else begin
      s <= next_s;
      up_wready_out <= (next_wf_cnt < WF_CNT_W'(W_DEPTH));
    end
  end

  assign up_awready_out = s.awready;
  assign dn_awvalid_out = s.aw_v;
  assign dn_awaddr_out = s.awaddr;
  assign dn_awid_out = s.awid;
  assign dn_awlen_out = s.awlen;
  assign dn_awsize_out = s.awsize;
  assign dn_awburst_out = s.awburst;
  assign dn_awlock_out = s.awlock;
  assign dn_wvalid_out = s.w_v;
  assign dn_wid_out = s.wid;
  assign dn_wdata_out = s.wdata;
  assign dn_wstrb_out = s.wstrb;
  assign dn_wlast_out = s.wlast;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  a_aw_held: assert property (dn_awvalid_out && !dn_awready_in |=>
    dn_awvalid_out && $stable(dn_awaddr_out) && $stable(dn_awid_out))
    else $error("address dropped or changed while stalled");
  a_w_held: assert property (dn_wvalid_out && !dn_wready_in |=>
    dn_wvalid_out && $stable(dn_wid_out) && $stable(dn_wlast_out))
    else $error("write beat dropped or changed while stalled");
  a_no_locked: assert property (dn_awvalid_out |-> !dn_awlock_out[1])
    else $error("locked transfer issued");
  a_id_bound: assert property (id_cnt <= ID_CNT_W'(ID_DEPTH))
    else $error("id fifo beyond depth");
  a_full_stall: assert property (id_cnt >= ID_ROOM_MARK && axi3_mode_in |-> ##1
    !up_awready_out || $past(id_pop))
    else $error("address ready high with id fifo full");
  a_push_count: assert property (id_push && !id_pop |=>
    id_cnt == $past(id_cnt) + ID_CNT_W'(1))
    else $error("address handshake did not push id");
  a_pop_count: assert property (id_pop && !id_push |=>
    id_cnt == $past(id_cnt) - ID_CNT_W'(1))
    else $error("last beat did not pop id");
  a_wid_head: assert property (w_load && axi3_mode_in |=>
    dn_wvalid_out && dn_wid_out == $past(id_head))
    else $error("wid not taken from id head");
  a_no_early: assert property (axi3_mode_in && !id_valid |-> !w_load)
    else $error("beat released before its address");
  a_reset_empty: assert property ($rose(rst_n) |-> id_cnt == '0 && !id_valid)
    else $error("id fifo not empty after reset");
  a_beat_room: assert property (up_wready_out |-> wf_cnt < WF_CNT_W'(W_DEPTH))
    else $error("data ready high with data buffer full");

  c_burst_done: cover property (dn_wvalid_out && dn_wready_in && dn_wlast_out);
  c_id_full: cover property (id_cnt == ID_ROOM_MARK);
  c_w_stall: cover property (dn_wvalid_out && !dn_wready_in ##1 !up_wready_out);
  c_two_ids: cover property (id_cnt == ID_CNT_W'(2) && dn_wvalid_out);
endmodule

`default_nettype wire

// file: tb/wir_dn_slave.sv
// downstream axi3 write slave model that checks wid against its own address log
`timescale 1ns/1ps
`default_nettype none
module wir_dn_slave
  import wir_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic stall_in,
  input wire logic mode_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic [ID_W-1:0] awid_in,
  input wire logic [DN_LEN_W-1:0] awlen_in,
  input wire logic [2:0] awsize_in,
  input wire logic [1:0] awburst_in,
  input wire logic [1:0] awlock_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [ID_W-1:0] wid_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [STRB_W-1:0] wstrb_in,
  input wire logic wlast_in,
  output var int errs_out,
  output var int beats_out,
  output logic [1:0] lock_out
);
  logic [ID_W-1:0] ids[$];
  logic [DN_LEN_W-1:0] lens[$];
  logic [ID_W-1:0] exp_wid;
  int nb;
  bit bad;
  logic tick;
  // ----------------------------------------------------------------
  // readies: address prompt, data only every other cycle
  // ----------------------------------------------------------------
  assign awready_out = !stall_in;
  assign wready_out = !stall_in && tick;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ids = {};
      lens = {};
      nb = 0;
      tick <= 1'b0;
      errs_out <= 0;
      beats_out <= 0;
      lock_out <= 2'h0;
    end else begin
      bad = 1'b0;
      tick <= !tick;
      if (awvalid_in && awready_out) begin
        ids.push_back(awid_in);
        lens.push_back(awlen_in);
        lock_out <= awlock_in;
        // the bench derives each address from its id; size and burst are tied
        if (awaddr_in !== ADDR_W'(awid_in) || awsize_in !== 3'h3 || awburst_in !== 2'h1) begin
          bad = 1'b1;
        end
      end
      if (wvalid_in && wready_out) begin
        beats_out <= beats_out + 1;
        if (ids.size() == 0 || lens.size() == 0) begin
          bad = 1'b1;
        end else begin
          exp_wid = mode_in ? ids[0] : WID_AXI4_VALUE;
          // data carries its burst id too, so a burst out of order shows here
          if (wid_in !== exp_wid || wdata_in[DATA_W-1 -: ID_W] !== ids[0] || wstrb_in !== '1) begin
            bad = 1'b1;
          end
          if (wlast_in) begin
            if (nb != int'(lens[0])) begin
              bad = 1'b1;
            end
            void'(ids.pop_front());
            void'(lens.pop_front());
            nb = 0;
          end else begin
            nb++;
          end
        end
      end
      if (bad) begin
        errs_out <= errs_out + 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/test_wir_axi3_wid_regen.sv
// self-checking testbench for the axi3 write id regenerator
`timescale 1ns/1ps
`default_nettype none
module test_wir_axi3_wid_regen;
  import wir_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic stall = 1'b0;
  logic awvalid = 1'b0;
  logic awlock = 1'b0;
  logic wvalid = 1'b0;
  logic wlast = 1'b0;
  logic mode = 1'b1;
  logic [ID_W-1:0] awid = '0;
  logic [UP_LEN_W-1:0] awlen = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic awready, wready, dn_awvalid, dn_awready, dn_wvalid, dn_wready, dn_wlast;
  logic [ID_W-1:0] dn_awid, dn_wid;
  logic [1:0] dn_awlock, lock_seen;
  logic [DATA_W-1:0] dn_wdata;
  logic [ADDR_W-1:0] dn_awaddr;
  logic [DN_LEN_W-1:0] dn_awlen;
  logic [2:0] dn_awsize;
  logic [1:0] dn_awburst;
  logic [STRB_W-1:0] dn_wstrb;
  int errs, beats;
  int fails = 0;
  int compares = 0;
  always #10 clk = ~clk;
  wir_axi3_wid_regen i_dut (.core_clk_in(clk), .nrst_in(nrst), .axi3_mode_in(mode),
    .up_awvalid_in(awvalid), .up_awready_out(awready), .up_awaddr_in({36'h0, awid}),
    .up_awid_in(awid), .up_awlen_in(awlen), .up_awsize_in(3'h3), .up_awburst_in(2'h1),
    .up_awlock_in(awlock), .up_wvalid_in(wvalid), .up_wready_out(wready),
    .up_wdata_in(wdata), .up_wstrb_in(8'hFF), .up_wlast_in(wlast),
    .dn_awvalid_out(dn_awvalid), .dn_awready_in(dn_awready), .dn_awaddr_out(dn_awaddr),
    .dn_awid_out(dn_awid), .dn_awlen_out(dn_awlen), .dn_awsize_out(dn_awsize),
    .dn_awburst_out(dn_awburst), .dn_awlock_out(dn_awlock), .dn_wvalid_out(dn_wvalid),
    .dn_wready_in(dn_wready), .dn_wid_out(dn_wid), .dn_wdata_out(dn_wdata),
    .dn_wstrb_out(dn_wstrb), .dn_wlast_out(dn_wlast));
  wir_dn_slave i_slave (.clk_in(clk), .rst_n_in(nrst), .stall_in(stall), .mode_in(mode),
    .awvalid_in(dn_awvalid), .awready_out(dn_awready), .awaddr_in(dn_awaddr),
    .awid_in(dn_awid), .awlen_in(dn_awlen), .awsize_in(dn_awsize), .awburst_in(dn_awburst),
    .awlock_in(dn_awlock), .wvalid_in(dn_wvalid), .wready_out(dn_wready), .wid_in(dn_wid),
    .wdata_in(dn_wdata), .wstrb_in(dn_wstrb), .wlast_in(dn_wlast), .errs_out(errs),
    .beats_out(beats), .lock_out(lock_seen));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ok tells whether the address was taken; a refused one is withdrawn
  task automatic send_aw(input logic [ID_W-1:0] id, input int len, output bit ok);
    int n;
    n = 0;
    @(negedge clk);
    awvalid = 1'b1;
    awid = id;
    awlen = UP_LEN_W'(len - 1);
    while (!awready && n < 20) begin
      @(negedge clk);
      n++;
    end
    ok = awready;
    @(negedge clk);
    awvalid = 1'b0;
  endtask
  task automatic send_w(input logic [ID_W-1:0] id, input int len);
    int n;
    @(negedge clk);
    for (int b = 0; b < len; b++) begin
      wvalid = 1'b1;
      wdata = {id, (DATA_W - ID_W)'(b)};
      wlast = (b == len - 1);
      n = 0;
      while (!wready && n < 200) begin
        @(negedge clk);
        n++;
      end
      @(negedge clk);
    end
    wvalid = 1'b0;
  endtask
  task automatic drain(input int exp);
    int n;
    n = 0;
    while (beats != exp && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(beats, exp, "beats out");
    chk(errs, 0, "wid or order errors");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    int n;
    @(negedge clk);
    nrst = 1'b0;
    repeat (16) @(negedge clk);
    chk(awready, 0, "awready in reset");
    chk(dn_wvalid, 0, "wvalid in reset");
    nrst = 1'b1;
    n = 0;
    while (!awready && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk(awready, 1, "awready after reset");
    $display("test reset done");
  endtask
  task automatic t_order;
    bit ok;
    send_aw(12'h001, 1, ok);
    send_aw(12'hFFF, 16, ok);
    send_aw(12'h800, 4, ok);
    send_w(12'h001, 1);
    send_w(12'hFFF, 16);
    send_w(12'h800, 4);
    drain(21);
    $display("test order done");
  endtask
  task automatic t_lock;
    bit ok;
    awlock = 1'b1;
    send_aw(12'h0A0, 2, ok);
    awlock = 1'b0;
    send_w(12'h0A0, 2);
    drain(23);
    chk(lock_seen, 2'h1, "lock field");
    $display("test lock done");
  endtask
  task automatic t_stall;
    bit ok;
    stall = 1'b1;
    send_aw(12'h077, 16, ok);
    fork
      send_w(12'h077, 16);
    join_none
    repeat (60) @(negedge clk);
    chk(beats, 23, "beats while stalled");
    chk(wready, 0, "data buffer full");
    stall = 1'b0;
    wait fork;
    drain(39);
    $display("test stall done");
  endtask
  task automatic t_rerst;
    bit ok;
    send_aw(12'h5A5, 2, ok);
    t_reset();
    send_aw(12'h3C3, 3, ok);
    send_w(12'h3C3, 3);
    drain(3);
    $display("test mid-run reset done");
  endtask
  task automatic t_fill;
    bit ok;
    int cnt;
    ok = 1'b1;
    cnt = 0;
    while (ok && cnt < ID_DEPTH + 2) begin
      send_aw(ID_W'(cnt), 1, ok);
      cnt += int'(ok);
    end
    chk(cnt, ID_DEPTH - 1, "addresses taken before refusal");
    for (int k = 0; k < cnt; k++) begin
      send_w(ID_W'(k), 1);
    end
    drain(3 + cnt);
    $display("test fill done");
  endtask
  // the mode tie-off is only changed while reset is held
  task automatic t_axi4;
    bit ok;
    nrst = 1'b0;
    mode = 1'b0;
    t_reset();
    send_aw(12'h123, 2, ok);
    send_w(12'h123, 2);
    chk(ok, 1, "axi4 address taken");
    drain(2);
    $display("test axi4 pass-through done");
  endtask
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    t_reset();
    t_order();
    t_lock();
    t_stall();
    t_rerst();
    t_fill();
    t_axi4();
    wrap_up();
  end
endmodule
`default_nettype wire
